// *** common/irtc_pkg.sv ***
// constants, register map and helpers for the ir timer control block
// assumes an apb slave with 32-bit data on a single 40 mhz clock
package irtc_pkg;

   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [7:0] IRTC_IDX_COMMON = 8'h01;
   localparam logic [7:0] IRTC_IDX_ENABLE = 8'h03;
   localparam logic [7:0] IRTC_IDX_STATUS = 8'h04;
   localparam logic [7:0] IRTC_IDX_CLEAR  = 8'h05;
   localparam logic [7:0] IRTC_IDX_IRQEN  = 8'h06;

   // ------------------------------------------------------------
   // common control field positions
   // ------------------------------------------------------------
   localparam int unsigned IRTC_CC_FLAG_FALL = 0;
   localparam int unsigned IRTC_CC_FLAG_RISE = 1;
   localparam int unsigned IRTC_CC_LO_FIELD  = 2;
   localparam int unsigned IRTC_CC_HI_FIELD  = 4;
   localparam int unsigned IRTC_CC_PIN_SEL   = 6;
   localparam int unsigned IRTC_CC_DEMOD     = 7;

   // ------------------------------------------------------------
   // enable control field positions and values
   // ------------------------------------------------------------
   localparam int unsigned IRTC_EN_T16    = 0;
   localparam int unsigned IRTC_EN_T8     = 1;
   localparam int unsigned IRTC_EN_SYNC   = 2;
   localparam logic [4:0]  IRTC_EN_RSVD   = 5'h1f;

   // ------------------------------------------------------------
   // edge and filter codes
   // ------------------------------------------------------------
   localparam logic [1:0] IRTC_EDGE_FALL  = 2'h0;
   localparam logic [1:0] IRTC_EDGE_RISE  = 2'h1;
   localparam logic [1:0] IRTC_EDGE_BOTH  = 2'h2;
   localparam logic [1:0] IRTC_FILT_NONE  = 2'h0;
   localparam logic [1:0] IRTC_FILT_4     = 2'h1;
   localparam logic [1:0] IRTC_FILT_8     = 2'h2;
   localparam logic [3:0] IRTC_FILT_CYC_4 = 4'h4;
   localparam logic [3:0] IRTC_FILT_CYC_8 = 4'h8;

   // ------------------------------------------------------------
   // interrupt status bits and reset values
   // ------------------------------------------------------------
   localparam int unsigned IRTC_ST_FALL  = 0;
   localparam int unsigned IRTC_ST_RISE  = 1;
   localparam logic [31:0] IRTC_ZERO32   = 32'h0000_0000;

   // apb address decode against a register index
   function automatic logic irtc_hit(input logic [7:0] paddr, input logic [7:0] idx);
      return paddr == {idx[5:0], 2'b00};
   endfunction

endpackage

// *** logic/irtc_edge_filt.sv ***
// noise filter and edge detector for the demodulator input
// assumes level is already synchronised to clk_sys
`timescale 1ns/10ps
module irtc_edge_filt
   import irtc_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // control
   input  wire logic       active,
   input  wire logic [1:0] filt_sel,
   input  wire logic [1:0] edge_sel,
   // input and events
   input  wire logic       level,
   output logic            fall_pulse,
   output logic            rise_pulse
);

   typedef struct packed {
      logic [3:0] cnt;
      logic       stable;
      logic       prev;
      logic       fall;
      logic       rise;
   } irtc_ef_state_t;

   irtc_ef_state_t s_q;
   irtc_ef_state_t s_d;

   function automatic logic [3:0] filt_need(input logic [1:0] sel);
      case (sel)
         IRTC_FILT_4: return IRTC_FILT_CYC_4;
         IRTC_FILT_8: return IRTC_FILT_CYC_8;
         default:     return 4'h0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // filter and edge logic
   // ------------------------------------------------------------
   always_comb
   begin
      logic [3:0] need;
      need = filt_need(filt_sel);
      s_d = s_q;
      if (!active)
      begin
         s_d.cnt    = 4'h0;
         s_d.stable = level;
      end
      else if (need == 4'h0 || level == s_q.stable)
      begin
         s_d.cnt    = 4'h0;
         s_d.stable = level;
      end
      else if (s_q.cnt + 4'h1 >= need)
      begin
         // change held long enough: accept it
         s_d.cnt    = 4'h0;
         s_d.stable = level;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 4'h1;
      end
      s_d.prev = s_q.stable;
      s_d.fall = active && s_q.prev && !s_q.stable
                 && (edge_sel == IRTC_EDGE_FALL || edge_sel == IRTC_EDGE_BOTH);
      s_d.rise = active && !s_q.prev && s_q.stable
                 && (edge_sel == IRTC_EDGE_RISE || edge_sel == IRTC_EDGE_BOTH);
      if (!active)
      begin
         s_d.prev = level;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign fall_pulse = s_q.fall;
   assign rise_pulse = s_q.rise;

endmodule

// *** logic/irtc_ctrl.sv ***
// ir timer mode and enable control with apb register access
// assumes pins arrive asynchronously; port data and timer output are on clk_sys
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module irtc_ctrl
   import irtc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        stop_recovery,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins and port logic
   input  wire logic        port3_bit1_pin,
   input  wire logic        port2_bit0_pin,
   input  wire logic        port_data_out,
   input  wire logic        timer_output_signal,
   output logic             port3_bit6_pin,
   // control to the timer datapaths
   output logic             demod_mode,
   output logic             pin_select,
   output logic [1:0]       hi_field,
   output logic [1:0]       lo_field,
   output logic             sixteen_bit_timer_init,
   output logic             eight_bit_timer_init,
   output logic             eight_bit_timer_en,
   output logic             sixteen_bit_timer_en,
   output logic             sync_mode,
   // events
   output logic             fall_edge_flag,
   output logic             rise_edge_flag,
   output logic             irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  sync1;
      logic [1:0]  sync2;
      logic [7:2]  ctl;
      logic [1:0]  tx_init;
      logic [1:0]  flags;
      logic [2:0]  en;
      logic [1:0]  stat;
      logic [1:0]  irqen;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic        pin;
      logic        irq;
   } irtc_state_t;

   irtc_state_t s_q;
   irtc_state_t s_d;

   logic fall_ev;
   logic rise_ev;
   logic demod_level;

   // ------------------------------------------------------------
   // demodulator input path
   // ------------------------------------------------------------
   // second synchroniser stage picks the input pin
   assign demod_level = s_q.ctl[IRTC_CC_PIN_SEL] ? s_q.sync2[1] : s_q.sync2[0];

   irtc_edge_filt u_edge
   (
      .clk_sys    (clk_sys),
      .reset      (reset),
      .active     (s_q.ctl[IRTC_CC_DEMOD]),
      .filt_sel   (s_q.ctl[IRTC_CC_LO_FIELD +: 2]),
      .edge_sel   (s_q.ctl[IRTC_CC_HI_FIELD +: 2]),
      .level      (demod_level),
      .fall_pulse (fall_ev),
      .rise_pulse (rise_ev)
   );

   // ------------------------------------------------------------
   // register read value
   // ------------------------------------------------------------
   function automatic logic [31:0] read_value(input irtc_state_t s,
                                              input logic [7:0]  addr);
      logic [31:0] v;
      v = IRTC_ZERO32;
      if (irtc_hit(addr, IRTC_IDX_COMMON))
      begin
         v[7:2] = s.ctl;
         // flags in demod mode, initial levels in transmit mode
         v[1:0] = s.ctl[IRTC_CC_DEMOD] ? s.flags : s.tx_init;
      end
      else if (irtc_hit(addr, IRTC_IDX_ENABLE))
      begin
         v[7:3] = IRTC_EN_RSVD;
         v[2:0] = s.en;
      end
      else if (irtc_hit(addr, IRTC_IDX_STATUS))
      begin
         v[1:0] = s.stat;
      end
      else if (irtc_hit(addr, IRTC_IDX_IRQEN))
      begin
         v[1:0] = s.irqen;
      end
      return v;
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      return irtc_hit(addr, IRTC_IDX_COMMON) || irtc_hit(addr, IRTC_IDX_ENABLE)
             || irtc_hit(addr, IRTC_IDX_STATUS) || irtc_hit(addr, IRTC_IDX_CLEAR)
             || irtc_hit(addr, IRTC_IDX_IRQEN);
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic       setup;
      logic       wr;
      logic [1:0] fl_clr;
      logic [1:0] st_clr;
      logic [1:0] ev;
      setup  = psel && !penable;
      wr     = psel && penable && pwrite && s_q.ready && !s_q.err;
      fl_clr = 2'b00;
      st_clr = 2'b00;
      ev     = {rise_ev, fall_ev};
      s_d    = s_q;

      // two-stage synchronisers for the pins
      s_d.sync1 = {port2_bit0_pin, port3_bit1_pin};
      s_d.sync2 = s_q.sync1;

      // apb answer: one wait-free access phase after setup
      if (setup)
      begin
         s_d.ready = 1'b1;
         s_d.err   = !mapped(paddr);
         s_d.rdata = pwrite ? IRTC_ZERO32 : read_value(s_q, paddr);
      end
      else
      begin
         s_d.ready = 1'b0;
         s_d.err   = 1'b0;
         s_d.rdata = IRTC_ZERO32;
      end

      // register writes
      if (wr && irtc_hit(paddr, IRTC_IDX_COMMON))
      begin
         s_d.ctl = pwdata[7:2];
         if (s_q.ctl[IRTC_CC_DEMOD])
         begin
            fl_clr = pwdata[1:0];
         end
         else
         begin
            s_d.tx_init = pwdata[1:0];
         end
      end
      if (wr && irtc_hit(paddr, IRTC_IDX_ENABLE))
      begin
         // upper bits are dropped on purpose
         s_d.en = pwdata[2:0];
      end
      if (wr && irtc_hit(paddr, IRTC_IDX_CLEAR))
      begin
         st_clr = pwdata[1:0];
      end
      if (wr && irtc_hit(paddr, IRTC_IDX_IRQEN))
      begin
         s_d.irqen = pwdata[1:0];
      end

      // stop recovery clears control, initial levels, flags and timer enables; sync mode, status and irq enables keep
      if (stop_recovery)
      begin
         s_d.ctl               = '0;
         s_d.tx_init           = 2'b00;
         fl_clr                = 2'b11;
         s_d.en[IRTC_EN_T8]    = 1'b0;
         s_d.en[IRTC_EN_T16]   = 1'b0;
         s_d.en[IRTC_EN_SYNC]  = s_q.en[IRTC_EN_SYNC];
      end

      // sticky flags: a new event wins over a clear
      s_d.flags = (s_q.flags & ~fl_clr) | ev;
      s_d.stat  = (s_q.stat & ~st_clr) | ev;
      s_d.irq   = |(s_d.stat & s_d.irqen);

      // pin routing in transmit mode
      if (!s_q.ctl[IRTC_CC_DEMOD] && s_q.ctl[IRTC_CC_PIN_SEL])
      begin
         s_d.pin = timer_output_signal;
      end
      else
      begin
         s_d.pin = port_data_out;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata                 = s_q.rdata;
   assign pready                 = s_q.ready;
   assign pslverr                = s_q.err;
   assign port3_bit6_pin         = s_q.pin;
   assign demod_mode             = s_q.ctl[IRTC_CC_DEMOD];
   assign pin_select             = s_q.ctl[IRTC_CC_PIN_SEL];
   assign hi_field               = s_q.ctl[IRTC_CC_HI_FIELD +: 2];
   assign lo_field               = s_q.ctl[IRTC_CC_LO_FIELD +: 2];
   assign sixteen_bit_timer_init = s_q.tx_init[IRTC_CC_FLAG_FALL];
   assign eight_bit_timer_init   = s_q.tx_init[IRTC_CC_FLAG_RISE];
   assign eight_bit_timer_en     = s_q.en[IRTC_EN_T8];
   assign sixteen_bit_timer_en   = s_q.en[IRTC_EN_T16];
   assign sync_mode              = s_q.en[IRTC_EN_SYNC];
   assign fall_edge_flag         = s_q.flags[IRTC_CC_FLAG_FALL];
   assign rise_edge_flag         = s_q.flags[IRTC_CC_FLAG_RISE];
   assign irq                    = s_q.irq;

endmodule

// *** testbench/irtc_ctrl_asserts.sv ***
// port checker for the ir timer control block
// assumes bind onto irtc_ctrl, one clk_sys domain
`timescale 1ns/10ps
module irtc_ctrl_asserts
(
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        stop_recovery,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   // pins and control
   input wire logic        port_data_out,
   input wire logic        timer_output_signal,
   input wire logic        port3_bit6_pin,
   input wire logic        demod_mode,
   input wire logic        pin_select,
   input wire logic        eight_bit_timer_en,
   input wire logic        sixteen_bit_timer_en,
   input wire logic        sync_mode,
   input wire logic        fall_edge_flag
);
   logic acc;
   logic wr;
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite && !stop_recovery;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_setup;
      psel && !penable;
   endsequence
   AST_APB_ZERO_WAIT: assert property (s_setup |=> pready)
      else $error("no pready after setup");
   AST_PIN_TIMER: assert property (!demod_mode && pin_select
      |=> port3_bit6_pin == $past(timer_output_signal)) else $error("pin not timer");
   AST_PIN_PORT: assert property (demod_mode || !pin_select
      |=> port3_bit6_pin == $past(port_data_out)) else $error("pin not port");
   AST_MODE_WR: assert property (wr && paddr == 8'h04
      |=> demod_mode == $past(pwdata[7])) else $error("mode bit wrong");
   AST_RSVD_ONES: assert property (acc && !pwrite && paddr == 8'h0C
      |-> prdata[7:3] == 5'h1f) else $error("reserved bits not ones");
   AST_SYNC_KEEP: assert property (stop_recovery && !acc |=> $stable(sync_mode))
      else $error("sync lost on recovery");
   AST_T8_EN: assert property (wr && paddr == 8'h0C
      |=> eight_bit_timer_en == $past(pwdata[1])) else $error("t8 enable wrong");
   AST_T16_EN: assert property (wr && paddr == 8'h0C
      |=> sixteen_bit_timer_en == $past(pwdata[0])) else $error("t16 enable wrong");
   AST_FLAG_DEMOD: assert property ($rose(fall_edge_flag) |-> $past(demod_mode, 2))
      else $error("flag outside demod");
endmodule
bind irtc_ctrl irtc_ctrl_asserts i_chk (.clk_sys, .reset, .stop_recovery, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .port_data_out, .timer_output_signal,
   .port3_bit6_pin, .demod_mode, .pin_select, .eight_bit_timer_en, .sixteen_bit_timer_en,
   .sync_mode, .fall_edge_flag);

// *** testbench/irtc_pin_model.sv ***
// port side model: ir input pins and port 3 output sources
// assumes the bench picks the active input pin and its level
`timescale 1ns/10ps
module irtc_pin_model
(
   // clock and control
   input wire logic clk_sys,
   input wire logic sel,
   input wire logic level,
   // pins
   output logic     port3_bit1_pin = 1'b1,
   output logic     port2_bit0_pin = 1'b1,
   output logic     port_data_out = 1'b0,
   output logic     timer_output_signal = 1'b0
);
   // idle input pin sits high, output sources keep moving
   always @(posedge clk_sys)
   begin
      port3_bit1_pin      <= sel ? 1'b1 : level;
      port2_bit0_pin      <= sel ? level : 1'b1;
      port_data_out       <= 1'($urandom);
      timer_output_signal <= ~timer_output_signal;
   end
endmodule

// *** testbench/tb.sv ***
// testbench for the ir timer control block
// assumes irtc_pkg, irtc_ctrl, pin model and bound checker
`timescale 1ns/10ps
module tb;
   import irtc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        stop_recovery = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        sel = 1'b0;
   logic        level = 1'b1;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, p31, p20, pdo, tos;
   logic        p36, t8i, t16i, rfl, ffl;
   logic [1:0]  hi_f, lo_f;
   logic [32:0] expq[$];
   int          miscompares = 0;
   int          tests_run = 0;
   int          cyc = 0;

   irtc_ctrl i_dut
   (
      .clk_sys, .reset, .stop_recovery, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .port3_bit1_pin(p31), .port2_bit0_pin(p20),
      .port_data_out(pdo), .timer_output_signal(tos), .port3_bit6_pin(p36),
      .demod_mode(), .pin_select(), .hi_field(hi_f), .lo_field(lo_f),
      .sixteen_bit_timer_init(t16i), .eight_bit_timer_init(t8i), .eight_bit_timer_en(),
      .sixteen_bit_timer_en(), .sync_mode(), .fall_edge_flag(ffl), .rise_edge_flag(rfl),
      .irq
   );
   irtc_pin_model i_pins
   (
      .clk_sys, .sel, .level, .port3_bit1_pin(p31), .port2_bit0_pin(p20),
      .port_data_out(pdo), .timer_output_signal(tos)
   );

   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
      tests_run++;
      if (s !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one apb transfer; reads leave {pslverr, prdata} expected in the queue
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      if (!w)
         expq.push_back(e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // pin follows timer output or port data one cycle later
   task automatic pin_chk(input logic tmr);
      logic tp;
      for (int k = 0; k < 8; k++)
      begin
         tp = tmr ? tos : pdo;
         @(posedge clk_sys);
         chk("pin", 33'(p36), 33'(tp));
      end
   endtask

   // read monitor and hang guard
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         end_of_test;
      end
      if (psel && penable && pready && !pwrite)
         chk("prdata", {pslverr, prdata}, expq.pop_front());
   end

   initial
   begin
      logic [7:0] cfg;
      logic [1:0] fl;
      void'($urandom(70012));
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      apb(1'b0, 8'h0C, 0, 33'h0_0000_00F8);
      apb(1'b0, 8'h04, 0, 0);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 8'h0C, 32'(i), 0);
         apb(1'b0, 8'h0C, 0, 33'(i) | 33'h0_0000_00F8);
      end
      stop_recovery <= 1'b1;
      @(posedge clk_sys);
      stop_recovery <= 1'b0;
      apb(1'b0, 8'h0C, 0, 33'h0_0000_00FC);
      $display("test enable done");
      apb(1'b1, 8'h04, 32'h0000_0043, 0);
      apb(1'b0, 8'h04, 0, 33'h0_0000_0043);
      chk("init", 33'({t8i, t16i}), 33'h0_0000_0003);
      pin_chk(1'b1);
      apb(1'b1, 8'h04, 0, 0);
      pin_chk(1'b0);
      $display("test routing done");
      for (int c = 0; c < 4; c++)
      begin
         cfg = {1'b1, 1'($urandom), 2'(c), 2'($urandom % 3), 2'b00};
         fl  = {c == 1 || c == 2, c == 0 || c == 2};
         sel <= cfg[6];
         apb(1'b1, 8'h18, 32'(~c & 3), 0);
         apb(1'b1, 8'h04, 32'(cfg), 0);
         chk("fields", 33'({hi_f, lo_f}), 33'(cfg[5:2]));
         pin_chk(1'b0);
         repeat (30) @(posedge clk_sys);
         apb(1'b1, 8'h04, 32'(cfg | 8'h03), 0);
         apb(1'b1, 8'h14, 32'h0000_0003, 0);
         level <= 1'b0;
         repeat (30) @(posedge clk_sys);
         level <= 1'b1;
         repeat (30) @(posedge clk_sys);
         apb(1'b0, 8'h04, 0, 33'(cfg | {6'h00, fl}));
         apb(1'b0, 8'h10, 0, 33'(fl));
         chk("irq", 33'(irq), 33'(|(fl & 2'(~c))));
         chk("flags", 33'({rfl, ffl}), 33'(fl));
         apb(1'b1, 8'h04, 32'(cfg), 0);
         apb(1'b0, 8'h04, 0, 33'(cfg | {6'h00, fl}));
         apb(1'b1, 8'h04, 32'(cfg | 8'h03), 0);
         apb(1'b1, 8'h14, 32'h0000_0003, 0);
         apb(1'b0, 8'h04, 0, 33'(cfg));
         apb(1'b0, 8'h14, 0, 0);
         chk("irq", 33'(irq), 0);
         $display("test edge code %0d done", c);
      end
      apb(1'b0, 8'h20, 0, 33'h1_0000_0000);
      $display("test unmapped done");
      end_of_test;
   end
endmodule
